// ===== rtl/kbc_cmd_pkg.sv
package kbc_cmd_pkg;

   // Host command codes.
   localparam logic [7:0] CMD_READ_CFG    = 8'h20;
   localparam logic [7:0] CMD_WRITE_CFG   = 8'h60;
   localparam logic [7:0] CMD_PWD_TEST    = 8'ha4;
   localparam logic [7:0] CMD_PWD_LOAD    = 8'ha5;
   localparam logic [7:0] CMD_PWD_ENABLE  = 8'ha6;
   localparam logic [7:0] CMD_AUX_DIS     = 8'ha7;
   localparam logic [7:0] CMD_AUX_EN      = 8'ha8;
   localparam logic [7:0] CMD_AUX_TEST    = 8'ha9;
   localparam logic [7:0] CMD_SELF_TEST   = 8'haa;
   localparam logic [7:0] CMD_KBD_TEST    = 8'hab;
   localparam logic [7:0] CMD_KBD_DIS     = 8'had;
   localparam logic [7:0] CMD_KBD_EN      = 8'hae;
   localparam logic [7:0] CMD_READ_IN     = 8'hc0;
   localparam logic [7:0] CMD_POLL_LO     = 8'hc1;
   localparam logic [7:0] CMD_POLL_HI     = 8'hc2;
   localparam logic [7:0] CMD_READ_OUT    = 8'hd0;
   localparam logic [7:0] CMD_WRITE_OUT   = 8'hd1;
   localparam logic [7:0] CMD_ECHO_KBD    = 8'hd2;
   localparam logic [7:0] CMD_ECHO_AUX    = 8'hd3;
   localparam logic [7:0] CMD_FWD_AUX     = 8'hd4;
   localparam logic [7:0] CMD_READ_TEST   = 8'he0;
   localparam logic [7:0] CMD_HW_RESET    = 8'hfe;
   localparam logic [3:0] CMD_PULSE_HI    = 4'hf;

   // Answers.
   localparam logic [7:0] ANS_PWD_LOADED  = 8'hfa;
   localparam logic [7:0] ANS_PWD_NONE    = 8'hf1;
   localparam logic [7:0] ANS_SELF_OK     = 8'h55;
   localparam logic [7:0] ANS_IF_OK       = 8'h00;
   localparam logic [7:0] ANS_CLK_LOW     = 8'h01;
   localparam logic [7:0] ANS_CLK_HIGH    = 8'h02;
   localparam logic [7:0] ANS_DAT_LOW     = 8'h03;
   localparam logic [7:0] ANS_DAT_HIGH    = 8'h04;

   // Configuration byte fields.
   localparam int CFG_TRANSLATE = 6;
   localparam int CFG_AUX_DIS   = 5;
   localparam int CFG_KBD_DIS   = 4;
   localparam int CFG_SYS_FLAG  = 2;
   localparam int CFG_AUX_IRQ   = 1;
   localparam int CFG_KBD_IRQ   = 0;
   localparam logic [7:0] CFG_RESET  = 8'h00;
   localparam logic [7:0] CFG_RW_MASK = 8'h77;

   // Register map on the plain register port.
   localparam logic [7:0] OFS_FAST_CTL   = 8'hf0;
   localparam logic [7:0] OFS_LEGACY     = 8'hf1;
   localparam logic [7:0] OFS_STATE      = 8'hf2;
   localparam int CTL_CLK_HI = 7;
   localparam int CTL_CLK_LO = 6;
   localparam int CTL_LEGACY_EN = 2;
   localparam int CTL_HW_GATE = 1;
   localparam int CTL_HW_RST  = 0;
   localparam logic [7:0] CTL_RESET     = 8'h00;
   localparam logic [7:0] CTL_RW_MASK   = 8'hc7;
   localparam int LEG_GATE = 1;
   localparam int LEG_RST  = 0;
   localparam logic [7:0] LEG_RESET     = 8'h24;
   localparam logic [7:0] LEG_FIXED     = 8'h24;

   // Reset pulse timing.
   localparam int CLK_MHZ       = 125;
   localparam int PULSE_US      = 6;
   localparam int DELAY_US      = 14;
   localparam int PULSE_CYC     = PULSE_US * CLK_MHZ;
   localparam int DELAY_CYC     = DELAY_US * CLK_MHZ;
   localparam int TMR_W         = 12;
   localparam int PWD_MAX       = 8;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_DELAY = 3'b001,
      ST_PULSE = 3'b011,
      ST_HOLD  = 3'b010
   } rst_seq_t;

   typedef struct packed {
      logic [7:0] data;
      logic       aux;
   } host_byte_t;

endpackage : kbc_cmd_pkg

// ===== rtl/kbc_cmd_reset_logic.sv
// Function
// - 20h returns configuration byte; 60h stores next data byte as configuration.
// - Config bits: 6 translate, 5 aux off, 4 kbd off, 2 sysflag, 1/0 irq enables.
// - A4h answers FAh when a password is held, F1h otherwise.
// - After A5h, up to seven password bytes load until a zero byte arrives; later bytes are dropped.
// - A6h enables keystroke comparison against the stored password.
// - A9h/ABh interface tests answer 00 to 04 by line fault.
// - AAh self-test answers 55h on success.
// - C0h sends input port one to the host.
// - C1h/C2h keep copying port one nibbles into status continuously.
// - D0h returns output port two.
// - D2h/D3h echo the next data byte as from keyboard or aux.
// - D4h forwards the next data byte to the auxiliary device.
// - E0h returns the test input states.
// - Even F0h-FFh codes pulse the reset line low about 6 us; FE with control bit 0 set starts the keyboard reset instead.
// - Control bits 7:6 indicate the controller clock rate.
// - Control bit 2 enables legacy port control of gate and reset.
// - Control bits 1/0 select hardware gate and reset fast logic.
// - Data after D1 sets gate from bit 1, reset from bit 0.
// - FE drives keyboard reset low 6 us after 14 us delay.
// - Firmware and hardware sources are exclusive; legacy port merges in.
// - Legacy port bit 1 drives the gate; resets to 24h, bits 5,2 one.
// - Legacy bit 0 pulses reset after delay; host clears before next.
//
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
module kbc_cmd_reset_logic (
   input  wire logic                      clk,
   input  wire logic                      sys_rst,
   input  wire logic                      host_cmd_wr,
   input  wire logic                      host_data_wr,
   input  wire logic [7:0]                host_wdata,
   output kbc_cmd_pkg::host_byte_t        host_answer,
   output logic                           host_answer_stb,
   output logic [7:0]                     aux_out_data,
   output logic                           aux_out_stb,
   output logic [7:0]                     kbd_out_data,
   output logic                           kbd_out_stb,
   input  wire logic [7:0]                input_port_one,
   input  wire logic [7:0]                test_inputs,
   input  wire logic [3:0]                line_faults,
   input  wire logic [7:0]                fw_port_two,
   input  wire logic [7:0]                key_code,
   input  wire logic                      key_stb,
   output logic                           pwd_match,
   output logic [7:0]                     config_byte,
   output logic [3:0]                     status_nibble,
   output logic                           status_nibble_hi,
   output logic                           status_poll_on,
   output logic                           address_line_gate,
   output logic                           kbd_reset_out,
   output logic                           reset_line_out,
   input  wire logic [7:0]                reg_addr,
   input  wire logic [7:0]                reg_wdata,
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   output logic [7:0]                     reg_rdata
);
   localparam int PWD_MAX_W = kbc_cmd_pkg::PWD_MAX * 8;

   typedef enum logic [1:0] {
      PEND_NONE = 2'b00,
      PEND_CFG  = 2'b01,
      PEND_ECHO = 2'b11,
      PEND_MISC = 2'b10
   } pend_t;

   typedef struct packed {
      pend_t                   pend;
      logic [7:0]              pend_cmd;
      logic [7:0]              cfg;
      logic [7:0]              ctl;
      logic [7:0]              legacy;
      logic                    pwd_loading;
      logic                    pwd_loaded;
      logic                    pwd_enabled;
      logic [2:0]              pwd_len;
      logic [2:0]              pwd_pos;
      logic [PWD_MAX_W-1:0]    pwd;
      logic                    pwd_match;
      logic                    poll_on;
      logic                    poll_hi;
      logic [3:0]              nibble;
      logic                    fw_gate;
      logic                    fw_rst;
      logic                    hw_gate;
      logic                    hw_rst;
      kbc_cmd_pkg::rst_seq_t   seq;
      logic [11:0]             tmr;
      logic                    seq_from_legacy;
      logic                    rc_low;
      logic [9:0]              rc_tmr;
      kbc_cmd_pkg::host_byte_t ans;
      logic                    ans_stb;
      logic [7:0]              aux_data;
      logic                    aux_stb;
      logic [7:0]              kbd_data;
      logic                    kbd_stb;
      logic [7:0]              rdata;
   } state_t;

   state_t s;
   state_t next_s;
   logic   legacy_rst_rise;
   logic   hw_rst_req;

   always_comb begin
      next_s = s;
      next_s.ans_stb = 1'b0;
      next_s.aux_stb = 1'b0;
      next_s.kbd_stb = 1'b0;
      next_s.pwd_match = 1'b0;
      hw_rst_req = 1'b0;
      legacy_rst_rise = 1'b0;
      if (host_cmd_wr) begin
         next_s.pend = PEND_NONE;
         next_s.pwd_loading = 1'b0;
         next_s.ans_stb = 1'b1;
         next_s.ans = '{data: 8'h00, aux: 1'b0};
         unique case (host_wdata)
            kbc_cmd_pkg::CMD_READ_CFG: next_s.ans.data = s.cfg;
            kbc_cmd_pkg::CMD_WRITE_CFG: begin
               next_s.ans_stb = 1'b0;
               next_s.pend = PEND_CFG;
            end
            kbc_cmd_pkg::CMD_PWD_TEST: begin
               next_s.ans.data = s.pwd_loaded ? kbc_cmd_pkg::ANS_PWD_LOADED : kbc_cmd_pkg::ANS_PWD_NONE;
            end
            kbc_cmd_pkg::CMD_PWD_LOAD: begin
               next_s.ans_stb = 1'b0;
               next_s.pwd_loading = 1'b1;
               next_s.pwd_loaded = 1'b0;
               next_s.pwd_enabled = 1'b0;
               next_s.pwd_len = 3'd0;
               next_s.pwd = '0;
            end
            kbc_cmd_pkg::CMD_PWD_ENABLE: begin
               next_s.ans_stb = 1'b0;
               next_s.pwd_enabled = s.pwd_loaded;
               next_s.pwd_pos = 3'd0;
            end
            kbc_cmd_pkg::CMD_AUX_DIS: begin
               next_s.ans_stb = 1'b0;
               next_s.cfg[kbc_cmd_pkg::CFG_AUX_DIS] = 1'b1;
            end
            kbc_cmd_pkg::CMD_AUX_EN: begin
               next_s.ans_stb = 1'b0;
               next_s.cfg[kbc_cmd_pkg::CFG_AUX_DIS] = 1'b0;
            end
            kbc_cmd_pkg::CMD_KBD_DIS: begin
               next_s.ans_stb = 1'b0;
               next_s.cfg[kbc_cmd_pkg::CFG_KBD_DIS] = 1'b1;
            end
            kbc_cmd_pkg::CMD_KBD_EN: begin
               next_s.ans_stb = 1'b0;
               next_s.cfg[kbc_cmd_pkg::CFG_KBD_DIS] = 1'b0;
            end
            kbc_cmd_pkg::CMD_AUX_TEST, kbc_cmd_pkg::CMD_KBD_TEST: begin
               // Fault bits: 0 clock low, 1 clock high, 2 data low, 3 data high.
               if (line_faults[0]) next_s.ans.data = kbc_cmd_pkg::ANS_CLK_LOW;
               else if (line_faults[1]) next_s.ans.data = kbc_cmd_pkg::ANS_CLK_HIGH;
               else if (line_faults[2]) next_s.ans.data = kbc_cmd_pkg::ANS_DAT_LOW;
               else if (line_faults[3]) next_s.ans.data = kbc_cmd_pkg::ANS_DAT_HIGH;
               else next_s.ans.data = kbc_cmd_pkg::ANS_IF_OK;
            end
            kbc_cmd_pkg::CMD_SELF_TEST: next_s.ans.data = kbc_cmd_pkg::ANS_SELF_OK;
            kbc_cmd_pkg::CMD_READ_IN: next_s.ans.data = input_port_one;
            kbc_cmd_pkg::CMD_POLL_LO, kbc_cmd_pkg::CMD_POLL_HI: begin
               next_s.ans_stb = 1'b0;
               next_s.poll_on = 1'b1;
               next_s.poll_hi = host_wdata[1];
            end
            kbc_cmd_pkg::CMD_READ_OUT: next_s.ans.data = fw_port_two;
            kbc_cmd_pkg::CMD_WRITE_OUT, kbc_cmd_pkg::CMD_ECHO_KBD,
            kbc_cmd_pkg::CMD_ECHO_AUX, kbc_cmd_pkg::CMD_FWD_AUX: begin
               next_s.ans_stb = 1'b0;
               next_s.pend = PEND_ECHO;
               next_s.pend_cmd = host_wdata;
            end
            kbc_cmd_pkg::CMD_READ_TEST: next_s.ans.data = test_inputs;
            default: begin
               next_s.ans_stb = 1'b0;
               if (host_wdata[7:4] == kbc_cmd_pkg::CMD_PULSE_HI && !host_wdata[0]) begin
                  if (host_wdata == kbc_cmd_pkg::CMD_HW_RESET && s.ctl[kbc_cmd_pkg::CTL_HW_RST]) begin
                     hw_rst_req = 1'b1;
                  end else begin
                     next_s.rc_low = 1'b1;
                     next_s.rc_tmr = 10'(kbc_cmd_pkg::PULSE_CYC);
                  end
               end
            end
         endcase
      end else if (host_data_wr) begin
         if (s.pwd_loading) begin
            if (host_wdata == 8'h00) begin
               next_s.pwd_loading = 1'b0;
               next_s.pwd_loaded = (s.pwd_len != 3'd0);
            end else if (s.pwd_len != 3'd7) begin
               next_s.pwd[s.pwd_len*8 +: 8] = host_wdata;
               next_s.pwd_len = s.pwd_len + 3'd1;
            end
         end else if (s.pend == PEND_CFG) begin
            next_s.cfg = host_wdata & kbc_cmd_pkg::CFG_RW_MASK;
            next_s.pend = PEND_NONE;
         end else if (s.pend == PEND_ECHO) begin
            next_s.pend = PEND_NONE;
            unique case (s.pend_cmd)
               kbc_cmd_pkg::CMD_WRITE_OUT: begin
                  if (s.ctl[kbc_cmd_pkg::CTL_HW_GATE]) next_s.hw_gate = host_wdata[1];
                  else next_s.fw_gate = host_wdata[1];
                  if (s.ctl[kbc_cmd_pkg::CTL_HW_RST]) next_s.hw_rst = host_wdata[0];
                  else next_s.fw_rst = host_wdata[0];
               end
               kbc_cmd_pkg::CMD_ECHO_KBD, kbc_cmd_pkg::CMD_ECHO_AUX: begin
                  next_s.ans_stb = 1'b1;
                  next_s.ans = '{data: host_wdata, aux: s.pend_cmd[0]};
               end
               default: begin
                  next_s.aux_stb = 1'b1;
                  next_s.aux_data = host_wdata;
               end
            endcase
         end else begin
            next_s.kbd_stb = 1'b1;
            next_s.kbd_data = host_wdata;
         end
      end
      if (key_stb && s.pwd_enabled) begin
         // Compare keystrokes in order; a full match restarts the walk.
         if (key_code == s.pwd[s.pwd_pos*8 +: 8]) begin
            if (s.pwd_pos + 3'd1 == s.pwd_len) begin
               next_s.pwd_match = 1'b1;
               next_s.pwd_pos = 3'd0;
            end else begin
               next_s.pwd_pos = s.pwd_pos + 3'd1;
            end
         end else begin
            next_s.pwd_pos = 3'd0;
         end
      end
      if (s.poll_on) next_s.nibble = s.poll_hi ? input_port_one[7:4] : input_port_one[3:0];
      if (s.rc_low) begin
         if (s.rc_tmr == 10'd1) next_s.rc_low = 1'b0;
         next_s.rc_tmr = s.rc_tmr - 10'd1;
      end
      if (reg_wr && reg_addr == kbc_cmd_pkg::OFS_FAST_CTL) next_s.ctl = reg_wdata & kbc_cmd_pkg::CTL_RW_MASK;
      if (reg_wr && reg_addr == kbc_cmd_pkg::OFS_LEGACY) begin
         next_s.legacy = (reg_wdata & 8'h03) | kbc_cmd_pkg::LEG_FIXED;
         legacy_rst_rise = reg_wdata[kbc_cmd_pkg::LEG_RST] && !s.legacy[kbc_cmd_pkg::LEG_RST]
                           && s.ctl[kbc_cmd_pkg::CTL_LEGACY_EN];
      end
      unique case (s.seq)
         kbc_cmd_pkg::ST_IDLE: begin
            if (hw_rst_req || legacy_rst_rise) begin
               next_s.seq = kbc_cmd_pkg::ST_DELAY;
               next_s.tmr = 12'(kbc_cmd_pkg::DELAY_CYC);
            end
         end
         kbc_cmd_pkg::ST_DELAY: begin
            next_s.tmr = s.tmr - 12'd1;
            if (s.tmr == 12'd1) begin
               next_s.seq = kbc_cmd_pkg::ST_PULSE;
               next_s.tmr = 12'(kbc_cmd_pkg::PULSE_CYC);
            end
         end
         kbc_cmd_pkg::ST_PULSE: begin
            next_s.tmr = s.tmr - 12'd1;
            if (s.tmr == 12'd1) next_s.seq = kbc_cmd_pkg::ST_HOLD;
         end
         kbc_cmd_pkg::ST_HOLD: next_s.seq = kbc_cmd_pkg::ST_IDLE;
         default: next_s.seq = kbc_cmd_pkg::ST_IDLE;
      endcase
      next_s.rdata = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            kbc_cmd_pkg::OFS_FAST_CTL: next_s.rdata = s.ctl;
            kbc_cmd_pkg::OFS_LEGACY:   next_s.rdata = s.legacy;
            kbc_cmd_pkg::OFS_STATE:    next_s.rdata = {address_line_gate, kbd_reset_out, reset_line_out,
                                                       s.pwd_loaded, s.pwd_enabled, s.seq != kbc_cmd_pkg::ST_IDLE,
                                                       s.pend != PEND_NONE, s.pwd_loading};
            default:                   next_s.rdata = 8'h00;
         endcase
      end
      if (sys_rst) begin
         next_s = '0;
         next_s.cfg = kbc_cmd_pkg::CFG_RESET;
         next_s.ctl = kbc_cmd_pkg::CTL_RESET;
         next_s.legacy = kbc_cmd_pkg::LEG_RESET;
         next_s.fw_gate = 1'b0;
         next_s.fw_rst = 1'b1;
         next_s.hw_rst = 1'b1;
         next_s.seq = kbc_cmd_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      s <= next_s;
   end

   // Firmware and hardware sources are exclusive per control bit; the legacy port merges in.
   always_comb begin
      address_line_gate = (s.ctl[kbc_cmd_pkg::CTL_HW_GATE] ? s.hw_gate : s.fw_gate)
                          | (s.ctl[kbc_cmd_pkg::CTL_LEGACY_EN] & s.legacy[kbc_cmd_pkg::LEG_GATE]);
      kbd_reset_out = (s.ctl[kbc_cmd_pkg::CTL_HW_RST] ? s.hw_rst : s.fw_rst)
                      & (s.seq != kbc_cmd_pkg::ST_PULSE);
   end

   assign reset_line_out   = !s.rc_low;
   assign host_answer      = s.ans;
   assign host_answer_stb  = s.ans_stb;
   assign aux_out_data     = s.aux_data;
   assign aux_out_stb      = s.aux_stb;
   assign kbd_out_data     = s.kbd_data;
   assign kbd_out_stb      = s.kbd_stb;
   assign pwd_match        = s.pwd_match;
   assign config_byte      = s.cfg;
   assign status_nibble    = s.nibble;
   assign status_nibble_hi = s.poll_hi;
   assign status_poll_on   = s.poll_on;
   assign reg_rdata        = s.rdata;

   a_self_test_ans: assert property (@(posedge clk) disable iff (sys_rst)
      host_cmd_wr && host_wdata == kbc_cmd_pkg::CMD_SELF_TEST |=> host_answer_stb && host_answer.data == 8'h55)
      else $error("self test answer wrong");
   a_cfg_read_ans: assert property (@(posedge clk) disable iff (sys_rst)
      host_cmd_wr && host_wdata == kbc_cmd_pkg::CMD_READ_CFG |=> host_answer.data == $past(s.cfg))
      else $error("config read answer wrong");
   a_pwd_test_ans: assert property (@(posedge clk) disable iff (sys_rst)
      host_cmd_wr && host_wdata == kbc_cmd_pkg::CMD_PWD_TEST && s.pwd_loaded |=> host_answer.data == 8'hfa)
      else $error("password test answer wrong");
   a_input_read_ans: assert property (@(posedge clk) disable iff (sys_rst)
      host_cmd_wr && host_wdata == kbc_cmd_pkg::CMD_READ_IN |=> host_answer.data == $past(input_port_one))
      else $error("input port answer wrong");
   a_fe_delay_gap: assert property (@(posedge clk) disable iff (sys_rst)
      s.seq == kbc_cmd_pkg::ST_IDLE ##1 s.seq == kbc_cmd_pkg::ST_DELAY |-> kbd_reset_out [*8])
      else $error("reset pulse started before delay");
   a_rc_pulse_low: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(reset_line_out) |-> !reset_line_out [*8])
      else $error("reset line pulse too short");
   a_gate_legacy_or: assert property (@(posedge clk) disable iff (sys_rst)
      s.ctl[kbc_cmd_pkg::CTL_LEGACY_EN] && s.legacy[kbc_cmd_pkg::LEG_GATE] |-> address_line_gate)
      else $error("legacy gate not merged");
   a_echo_aux_flag: assert property (@(posedge clk) disable iff (sys_rst)
      host_data_wr && s.pend == PEND_ECHO && s.pend_cmd == kbc_cmd_pkg::CMD_ECHO_AUX && !s.pwd_loading
      |=> host_answer_stb && host_answer.aux && host_answer.data == $past(host_wdata))
      else $error("aux echo wrong");

endmodule : kbc_cmd_reset_logic

// ===== bench/kbc_host_model.sv
`timescale 1ns/10ps
module kbc_host_model (
   input  wire logic       clk,
   output logic            host_cmd_wr,
   output logic            host_data_wr,
   output logic [7:0]      host_wdata
);
   initial begin
      host_cmd_wr = 1'b0;
      host_data_wr = 1'b0;
      host_wdata = 8'h00;
   end
   // One byte per call; the lines are dropped at the edge that takes it.
   task automatic put(input logic is_cmd, input logic [7:0] b);
      @(posedge clk);
      host_cmd_wr <= is_cmd;
      host_data_wr <= !is_cmd;
      host_wdata <= b;
      @(posedge clk);
      host_cmd_wr <= 1'b0;
      host_data_wr <= 1'b0;
      host_wdata <= ~b;
   endtask : put
   task automatic load_pwd(input logic [7:0] b);
      put(1'b1, kbc_cmd_pkg::CMD_PWD_LOAD);
      put(1'b0, b);
      put(1'b0, 8'h00);
   endtask : load_pwd
endmodule : kbc_host_model

// ===== bench/kbc_cmd_reset_logic_bench.sv
`timescale 1ns/10ps
module kbc_cmd_reset_logic_bench;
   logic                    clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, key_stb = 1'b0;
   logic                    host_cmd_wr, host_data_wr, host_answer_stb, aux_out_stb, pwd_match, seen;
   logic [7:0]              host_wdata, aux_out_data, reg_rdata, reg_addr = 8'h00, reg_wdata = 8'h00;
   logic [7:0]              input_port_one = 8'h00, test_inputs = 8'h00, fw_port_two = 8'h00, key_code = 8'h00;
   logic [3:0]              line_faults = 4'h0, status_nibble;
   logic                    address_line_gate, kbd_reset_out, reset_line_out;
   kbc_cmd_pkg::host_byte_t host_answer;
   int                      n_errors = 0, num_checks = 0, cycles = 0;
   initial forever #4 clk = ~clk;
   kbc_host_model host_u (.clk(clk), .host_cmd_wr(host_cmd_wr), .host_data_wr(host_data_wr),
                          .host_wdata(host_wdata));
   kbc_cmd_reset_logic dut_u (.clk(clk), .sys_rst(sys_rst), .host_cmd_wr(host_cmd_wr),
      .host_data_wr(host_data_wr), .host_wdata(host_wdata), .host_answer(host_answer),
      .host_answer_stb(host_answer_stb), .aux_out_data(aux_out_data), .aux_out_stb(aux_out_stb),
      .kbd_out_data(), .kbd_out_stb(), .input_port_one(input_port_one), .test_inputs(test_inputs),
      .line_faults(line_faults), .fw_port_two(fw_port_two), .key_code(key_code), .key_stb(key_stb),
      .pwd_match(pwd_match), .config_byte(), .status_nibble(status_nibble), .status_nibble_hi(),
      .status_poll_on(), .address_line_gate(address_line_gate), .kbd_reset_out(kbd_reset_out),
      .reset_line_out(reset_line_out), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   task automatic wrap_up;
      $display("checks=%0d errors=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask : rd
   // Command whose answer shows in the cycle after the taking edge.
   task automatic ask(input logic [7:0] c, input logic [7:0] exp, input logic aux);
      host_u.put(1'b1, c);
      #1 chk({host_answer_stb, host_answer}, {1'b1, exp, aux});
   endtask : ask
   // The keyboard reset line stays high through the delay, then is low for the pulse.
   task automatic pulse_chk;
      cyc(1700);
      chk({kbd_reset_out, reset_line_out}, 2'b11);
      cyc(100);
      chk(kbd_reset_out, 1'b0);
      cyc(600);
      chk(kbd_reset_out, 1'b0);
      cyc(200);
      chk(kbd_reset_out, 1'b1);
   endtask : pulse_chk
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         wrap_up();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      rd(8'hf0, 8'h00);
      rd(8'hf1, 8'h24);
      chk({address_line_gate, kbd_reset_out, reset_line_out}, 3'b011);
      wr(8'hf0, 8'hff);
      rd(8'hf0, 8'hc7);
      wr(8'hf3, 8'h5a);
      rd(8'hf3, 8'h00);
      wr(8'hf0, 8'h04);
      wr(8'hf1, 8'h02);
      rd(8'hf1, 8'h26);
      chk(address_line_gate, 1'b1);
      wr(8'hf0, 8'h00);
      cyc(1);
      chk(address_line_gate, 1'b0);
      wr(8'hf0, 8'h02);
      host_u.put(1'b1, kbc_cmd_pkg::CMD_WRITE_OUT);
      host_u.put(1'b0, 8'h02);
      cyc(1);
      chk(address_line_gate, 1'b1);
      host_u.put(1'b1, kbc_cmd_pkg::CMD_WRITE_OUT);
      host_u.put(1'b0, 8'h01);
      cyc(1);
      chk({address_line_gate, kbd_reset_out}, 2'b01);
      host_u.put(1'b1, kbc_cmd_pkg::CMD_WRITE_CFG);
      host_u.put(1'b0, 8'h77);
      ask(kbc_cmd_pkg::CMD_READ_CFG, 8'h77, 1'b0);
      ask(kbc_cmd_pkg::CMD_PWD_TEST, 8'hf1, 1'b0);
      host_u.load_pwd(8'h1c);
      ask(kbc_cmd_pkg::CMD_PWD_TEST, 8'hfa, 1'b0);
      host_u.put(1'b1, kbc_cmd_pkg::CMD_PWD_ENABLE);
      key_code <= 8'h1c;
      key_stb <= 1'b1;
      @(posedge clk);
      key_stb <= 1'b0;
      #1 seen = pwd_match;
      repeat (3) begin
         cyc(1);
         seen |= pwd_match;
      end
      chk(seen, 1'b1);
      ask(kbc_cmd_pkg::CMD_SELF_TEST, 8'h55, 1'b0);
      for (int i = 0; i < 5; i++) begin
         line_faults <= (i == 0) ? 4'h0 : 4'(4'h1 << (i - 1));
         ask(kbc_cmd_pkg::CMD_KBD_TEST, 8'(i), 1'b0);
         ask(kbc_cmd_pkg::CMD_AUX_TEST, 8'(i), 1'b0);
      end
      input_port_one <= 8'ha5;
      fw_port_two <= 8'h69;
      test_inputs <= 8'h03;
      ask(kbc_cmd_pkg::CMD_READ_IN, 8'ha5, 1'b0);
      ask(kbc_cmd_pkg::CMD_READ_OUT, 8'h69, 1'b0);
      ask(kbc_cmd_pkg::CMD_READ_TEST, 8'h03, 1'b0);
      host_u.put(1'b1, kbc_cmd_pkg::CMD_ECHO_KBD);
      host_u.put(1'b0, 8'h5a);
      #1 chk({host_answer_stb, host_answer}, {1'b1, 8'h5a, 1'b0});
      host_u.put(1'b1, kbc_cmd_pkg::CMD_ECHO_AUX);
      host_u.put(1'b0, 8'h96);
      #1 chk({host_answer_stb, host_answer}, {1'b1, 8'h96, 1'b1});
      host_u.put(1'b1, kbc_cmd_pkg::CMD_FWD_AUX);
      host_u.put(1'b0, 8'h3c);
      #1 chk({aux_out_stb, aux_out_data}, {1'b1, 8'h3c});
      host_u.put(1'b1, kbc_cmd_pkg::CMD_POLL_LO);
      cyc(2);
      chk(status_nibble, 4'h5);
      input_port_one <= 8'h3c;
      cyc(2);
      chk(status_nibble, 4'hc);
      host_u.put(1'b1, kbc_cmd_pkg::CMD_POLL_HI);
      cyc(2);
      chk(status_nibble, 4'h3);
      host_u.put(1'b1, 8'hf0);
      cyc(10);
      chk({kbd_reset_out, reset_line_out}, 2'b10);
      cyc(800);
      chk(reset_line_out, 1'b1);
      wr(8'hf0, 8'h01);
      host_u.put(1'b1, kbc_cmd_pkg::CMD_HW_RESET);
      pulse_chk();
      wr(8'hf0, 8'h05);
      wr(8'hf1, 8'h01);
      pulse_chk();
      wr(8'hf1, 8'h00);
      wrap_up();
   end
endmodule : kbc_cmd_reset_logic_bench
